// File: rts_pkg.sv
`default_nettype none
package rts_pkg;
  // ********************************
  // register map
  // ********************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_SEQ_CFG_ONE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SEQ_CFG_TWO = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_TIMER_ONE = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_TIMER_TWO = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_RX_TIMEOUT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PKT_CFG_TWO = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_EVENT_MAP = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7;

  // sequencer_config_one fields
  localparam int B_START = 0;
  localparam int B_HALT = 1;
  localparam int B_IDLE_SEL = 2;
  localparam int B_LP_SEL = 3;
  localparam int B_IDLE_EXIT = 4;
  localparam int F_START_SEL = 5;
  // sequencer_config_two fields
  localparam int F_RX_EXIT = 0;
  localparam int F_RXTO_EXIT = 3;
  localparam int B_TX_EXIT = 5;
  // packet_config_two fields
  localparam int B_REPEAT = 8;
  localparam int B_PRE_MAP = 0;

  // ********************************
  // encodings
  // ********************************
  localparam logic [1:0] START_TO_LP = 2'h0;
  localparam logic [2:0] RX_EXIT_OFF_ON_SYNC = 3'h5;
  localparam logic [1:0] RXTO_TO_LP = 2'h2;
  localparam logic [1:0] EV_SEL_00 = 2'h0;
  localparam logic [1:0] EV_SEL_01 = 2'h1;
  localparam logic [1:0] EV_SEL_10 = 2'h2;
  localparam logic [1:0] EV_SEL_11 = 2'h3;
  localparam int NUM_LINES = 5;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_HZ = 40_000_000;
  localparam int TIMER_MIN_US = 64;
  localparam int TICK_CYCLES = (TIMER_MIN_US * (CLK_HZ / 1_000_000));
  localparam int TIMER_W = 16;
  localparam logic [31:0] BUS_DATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    RTS_OFF, RTS_LOWPOWER, RTS_IDLE, RTS_TIMER_TWO_IDLE, RTS_RX, RTS_RX_HOLD, RTS_TX
  } rts_state_t;
endpackage
`default_nettype wire

// File: rts_radio_model.sv
`default_nettype none
module rts_radio_model (
  input wire logic sys_clk,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic sync_en,
  output logic preamble_found_in,
  output logic sync_word_match_in,
  output logic packet_done_tx_in
);
  // ********
  // radio stand-in: fixed airtime, sync only when the bench asks
  // ********
  int tc = 0;
  int rc = 0;
  always @(posedge sys_clk) begin
    tc <= tx_on ? tc + 1 : 0;
    rc <= rx_on ? rc + 1 : 0;
  end
  assign packet_done_tx_in = tx_on && tc > 3;
  assign preamble_found_in = sync_en && rc > 0;
  assign sync_word_match_in = sync_en && rc > 2;
endmodule
`default_nettype wire

// File: rts_sequencer.sv
// Notes on behaviour
// RULE1: on a valid sync word during a listen cycle, pulse sync_word_match, stop the sequencer, stay in receive.
// RULE2: at start, code 00 goes to low-power selection, value 1 there enters idle, idle value 1 means sleep.
// RULE3: in idle, idle_interval_timer expiry goes to receive if idle_exit_select is 1, else transmit.
// RULE4: receive_exit_select 101 turns the sequencer off on sync_word_match in receive.
// RULE5: rx_timeout_exit_select 10 sends a receive timeout back to low-power selection.
// RULE6: transmit_exit_select 0 leaves transmit for low-power selection on packet_done_tx.
// RULE7: beacon mode transmits once per sum of both timers and returns to idle once sent.
// RULE8: the beacon loop runs until the host sets sequencer_halt.
// RULE9: with repeat_payload_enable set the stored payload is resent every period.
// RULE10: host should program idle_interval_timer to its 64 us minimum for sync wake.
// RULE11: host sets second_interval_timer so both timers sum to the reception interval.
// RULE12: host keeps preamble_wait_limit just long enough to catch a preamble.
// RULE13: transmitted preamble should last second_interval_timer minus the sync time.
// RULE14: recommended event line codes: 0=01, 1=00, 2=11, 3=00, 4=11 with preamble_map_select.
// RULE15: after preamble, receive holds until sync or end of second_interval_timer, then polls on.
// RULE16: idle is sleep with only the rc oscillator running so timers keep counting.
// RULE17: the timers run back to back; idle timer expiry starts the second, whose expiry restarts.
//
// Design decisions made here: the address map and the Avalon-MM register port.
`default_nettype none
module rts_sequencer #(
  parameter int TICK = rts_pkg::TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [rts_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic preamble_found_in,
  input wire logic sync_word_match_in,
  input wire logic packet_done_tx_in,
  input wire logic checksum_pass_in,
  input wire logic buffer_threshold_in,
  input wire logic buffer_drained_in,
  output logic rx_on,
  output logic tx_on,
  output logic sleep_on,
  output logic rc_osc_on,
  output logic payload_resend,
  output logic [rts_pkg::NUM_LINES-1:0] event_output_line
);
  import rts_pkg::*;

  // ********************************
  // input synchronisers
  // ********************************
  logic [5:0] ev_meta;
  logic [5:0] ev_sync;
  logic [5:0] ev_prev;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ev_meta <= '0;
      ev_sync <= '0;
      ev_prev <= '0;
    end else begin
      ev_meta <= {buffer_drained_in, buffer_threshold_in, checksum_pass_in,
                  packet_done_tx_in, sync_word_match_in, preamble_found_in};
      ev_sync <= ev_meta;
      ev_prev <= ev_sync;
    end
  end
  wire logic pre_lvl = ev_sync[0];
  wire logic sync_rise = ev_sync[1] & ~ev_prev[1];
  wire logic sent_rise = ev_sync[2] & ~ev_prev[2];

  // ********************************
  // registers
  // ********************************
  logic [7:0] seq_cfg_one;
  logic [7:0] seq_cfg_two;
  logic [TIMER_W-1:0] timer_one;
  logic [TIMER_W-1:0] timer_two;
  logic [TIMER_W-1:0] rx_timeout;
  logic [8:0] pkt_cfg_two;
  logic [9:0] event_map;
  logic ack;
  rts_state_t state;
  rts_state_t next_state;

  // one-cycle wait so each access ends on the edge after it is seen
  wire logic req = (avs_read | avs_write) & ~ack;
  wire logic wr_en = avs_write & ~ack;
  wire logic wr_one = wr_en && avs_address == OFS_SEQ_CFG_ONE;
  wire logic start_cmd = wr_one & avs_writedata[B_START];
  wire logic halt_cmd = wr_one & avs_writedata[B_HALT];
  wire logic running = state != RTS_OFF;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seq_cfg_one <= 8'h00;
      seq_cfg_two <= 8'h00;
      timer_one <= 16'h0001;
      timer_two <= 16'h0001;
      rx_timeout <= 16'h0001;
      pkt_cfg_two <= 9'h000;
      event_map <= 10'h000;
    end else if (wr_en) begin
      unique case (avs_address)
        OFS_SEQ_CFG_ONE: seq_cfg_one <= {avs_writedata[7:2], 2'h0};
        OFS_SEQ_CFG_TWO: seq_cfg_two <= avs_writedata[7:0];
        OFS_TIMER_ONE: timer_one <= avs_writedata[TIMER_W-1:0];
        OFS_TIMER_TWO: timer_two <= avs_writedata[TIMER_W-1:0];
        OFS_RX_TIMEOUT: rx_timeout <= avs_writedata[TIMER_W-1:0];
        OFS_PKT_CFG_TWO: pkt_cfg_two <= avs_writedata[8:0];
        OFS_EVENT_MAP: event_map <= avs_writedata[9:0];
        default: ;
      endcase
    end
  end

  wire logic idle_sel = seq_cfg_one[B_IDLE_SEL];
  wire logic lp_sel = seq_cfg_one[B_LP_SEL];
  wire logic idle_exit_sel = seq_cfg_one[B_IDLE_EXIT];
  wire logic [1:0] start_sel = seq_cfg_one[F_START_SEL +: 2];
  wire logic [2:0] rx_exit_sel = seq_cfg_two[F_RX_EXIT +: 3];
  wire logic [1:0] rxto_exit_sel = seq_cfg_two[F_RXTO_EXIT +: 2];
  wire logic tx_exit_sel = seq_cfg_two[B_TX_EXIT];
  wire logic repeat_en = pkt_cfg_two[B_REPEAT];
  wire logic pre_map = pkt_cfg_two[B_PRE_MAP];

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = BUS_DATA_ZERO;
    unique case (avs_address)
      OFS_SEQ_CFG_ONE: rd_mux = {24'h0, seq_cfg_one};
      OFS_SEQ_CFG_TWO: rd_mux = {24'h0, seq_cfg_two};
      OFS_TIMER_ONE: rd_mux = {16'h0, timer_one};
      OFS_TIMER_TWO: rd_mux = {16'h0, timer_two};
      OFS_RX_TIMEOUT: rd_mux = {16'h0, rx_timeout};
      OFS_PKT_CFG_TWO: rd_mux = {23'h0, pkt_cfg_two};
      OFS_EVENT_MAP: rd_mux = {22'h0, event_map};
      OFS_STATUS: rd_mux = {28'h0, running, 3'(state)};
      default: rd_mux = BUS_DATA_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= BUS_DATA_ZERO;
    end else begin
      ack <= req;
      // registered so the bus answer leaves straight from a flip-flop
      avs_waitrequest <= ~req;
      if (avs_read & ~ack) avs_readdata <= rd_mux;
    end
  end

  // ********************************
  // timebase and timers
  // ********************************
  // timers count in 64 us ticks taken from the rc-equivalent prescaler
  logic [15:0] pre_cnt;
  logic [TIMER_W-1:0] t1_cnt;
  logic [TIMER_W-1:0] t2_cnt;
  logic [TIMER_W-1:0] rxto_cnt;
  logic t1_run;
  logic t2_run;
  wire logic tick = pre_cnt == 16'(TICK - 1);
  wire logic t1_exp = t1_run & tick & (t1_cnt <= 16'h0001);
  wire logic t2_exp = t2_run & tick & (t2_cnt <= 16'h0001);
  wire logic in_rx = state == RTS_RX;
  wire logic rxto_exp = in_rx & tick & (rxto_cnt <= 16'h0001);

  always_ff @(posedge sys_clk) begin
    if (sys_rst | ~running) begin
      pre_cnt <= 16'h0000;
      t1_cnt <= 16'h0000;
      t2_cnt <= 16'h0000;
      t1_run <= 1'b0;
      t2_run <= 1'b0;
    end else begin
      pre_cnt <= tick ? 16'h0000 : pre_cnt + 16'h0001;
      if (t1_exp | (~t1_run & ~t2_run)) begin
        t1_run <= ~t1_exp; // RULE17
        t2_run <= t1_exp; // RULE17
        t1_cnt <= timer_one;
        t2_cnt <= timer_two;
      end else if (t2_exp) begin
        t2_run <= 1'b0; // RULE17
        t1_run <= 1'b1; // RULE17
        t1_cnt <= timer_one;
      end else if (tick) begin
        if (t1_run) t1_cnt <= t1_cnt - 16'h0001;
        if (t2_run) t2_cnt <= t2_cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst | ~in_rx) rxto_cnt <= rx_timeout;
    else if (tick) rxto_cnt <= rxto_cnt - 16'h0001;
  end

  // ********************************
  // sequencer
  // ********************************
  always_comb begin
    next_state = state;
    unique case (state)
      RTS_OFF:
        if (start_cmd && start_sel == START_TO_LP) next_state = RTS_LOWPOWER; // RULE2
      RTS_LOWPOWER:
        next_state = lp_sel ? RTS_IDLE : RTS_TIMER_TWO_IDLE; // RULE2
      RTS_IDLE:
        if (t1_exp) next_state = idle_exit_sel ? RTS_RX : RTS_TX; // RULE3
      RTS_TIMER_TWO_IDLE:
        if (t2_exp) next_state = RTS_LOWPOWER;
      RTS_RX:
        if (sync_rise && rx_exit_sel == RX_EXIT_OFF_ON_SYNC) next_state = RTS_OFF; // RULE4
        else if (pre_lvl) next_state = RTS_RX_HOLD; // RULE15
        else if (rxto_exp && rxto_exit_sel == RXTO_TO_LP) next_state = RTS_LOWPOWER; // RULE5
      RTS_RX_HOLD:
        if (sync_rise && rx_exit_sel == RX_EXIT_OFF_ON_SYNC) next_state = RTS_OFF; // RULE1
        else if (t2_exp) next_state = RTS_LOWPOWER; // RULE15
      RTS_TX:
        if (sent_rise && !tx_exit_sel) next_state = RTS_LOWPOWER; // RULE6 RULE7
      default: next_state = RTS_OFF;
    endcase
    if (halt_cmd) next_state = RTS_OFF; // RULE8
  end

  // receive stays on after a sync stop until the host writes another mode
  logic rx_hold_off;
  wire logic sync_stop = (state == RTS_RX || state == RTS_RX_HOLD) && next_state == RTS_OFF
                         && !halt_cmd;
  wire logic any_wr = wr_one;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= RTS_OFF;
      rx_hold_off <= 1'b0;
      rx_on <= 1'b0;
      tx_on <= 1'b0;
      sleep_on <= 1'b0;
      rc_osc_on <= 1'b0;
      payload_resend <= 1'b0;
    end else begin
      state <= next_state;
      if (sync_stop) rx_hold_off <= 1'b1; // RULE1
      else if (any_wr) rx_hold_off <= 1'b0;
      rx_on <= next_state == RTS_RX || next_state == RTS_RX_HOLD || sync_stop
               || (rx_hold_off && !any_wr); // RULE1
      tx_on <= next_state == RTS_TX; // RULE7
      sleep_on <= (next_state == RTS_IDLE) && idle_sel; // RULE16
      rc_osc_on <= next_state != RTS_OFF; // RULE16
      payload_resend <= state != RTS_TX && next_state == RTS_TX && repeat_en; // RULE9
    end
  end

  // ********************************
  // event lines
  // ********************************
  wire logic [3:0] src [NUM_LINES];
  assign src[0] = {1'b0, 1'b0, checksum_pass_sel(ev_sync), 1'b0};
  assign src[1] = {3'h0, ev_sync[4]};
  assign src[2] = {ev_sync[1], 3'h0};
  assign src[3] = {3'h0, ev_sync[5]};
  assign src[4] = {pre_map & pre_lvl, 3'h0};

  function automatic logic checksum_pass_sel(input logic [5:0] e);
    return e[3];
  endfunction

  // one register process for all lines keeps a single driver on the port
  wire logic [NUM_LINES-1:0] next_lines;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      wire logic [1:0] sel = event_map[2*gi +: 2];
      assign next_lines[gi] = src[gi][sel]; // RULE14
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (sys_rst) event_output_line <= '0;
    else event_output_line <= next_lines;
  end
endmodule
`default_nettype wire

// File: rts_sequencer_bench.sv
`default_nettype none
module rts_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rts_pkg::*;
  // ********
  // harness
  // ********
  localparam int T = 4;
  logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, sync_en = 0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, q, seed = 32'h2D;
  logic avs_waitrequest, preamble_found_in, sync_word_match_in, packet_done_tx_in;
  logic checksum_pass_in = 0, buffer_threshold_in = 0, buffer_drained_in = 0;
  logic rx_on, tx_on, sleep_on, rc_osc_on, payload_resend;
  logic [NUM_LINES-1:0] event_output_line;
  int miscompares = 0, checks = 0, resends = 0, n, a, p1, p2, t2;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (payload_resend === 1'b1) resends <= resends + 1;
  rts_sequencer #(.TICK(T)) rts_sequencer_i (.*);
  rts_radio_model rts_radio_model_i (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] cfg1(input logic ex);
    return {27'h0, ex, 1'b1, 1'b1, 1'b0, 1'b1};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read or write held until waitrequest is sampled low, then one idle edge
  task automatic bus(input logic [ADDR_W-1:0] ad, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge sys_clk);
  endtask
  task automatic wait_for(ref logic s, input logic v, output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (s !== v && c < 400);
    chk(s, v);
  endtask
  task automatic summarize;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #500us;
    miscompares++;
    summarize;
  end
  // ********
  // scenarios
  // ********
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    for (int i = 2; i < 5; i++) begin
      bus(4'(i), 0, 0, q);
      chk(q, 1);
    end
    bus(4'hF, 1, '1, q);
    bus(4'hF, 0, 0, q);
    chk(q, 0);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      bus(OFS_EVENT_MAP, 1, {22'h0, seed[9:0]}, q);
      bus(OFS_EVENT_MAP, 0, 0, q);
      chk(q, {22'h0, seed[9:0]});
    end
    bus(OFS_EVENT_MAP, 1, 32'h331, q);
    bus(OFS_PKT_CFG_TWO, 1, 32'h101, q);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      checksum_pass_in <= seed[0];
      buffer_threshold_in <= seed[1];
      buffer_drained_in <= seed[2];
      repeat (6) @(posedge sys_clk);
      chk(event_output_line[0], seed[0]);
      chk(event_output_line[1], seed[1]);
      chk(event_output_line[3], seed[2]);
    end
    t2 = 3 + seed[4:3];
    bus(OFS_TIMER_ONE, 1, 1, q);
    bus(OFS_TIMER_TWO, 1, t2, q);
    bus(OFS_RX_TIMEOUT, 1, 2, q);
    bus(OFS_SEQ_CFG_TWO, 1, 32'h15, q);
    bus(OFS_SEQ_CFG_ONE, 1, cfg1(1), q);
    wait_for(sleep_on, 1, n);
    chk(rc_osc_on, 1);
    wait_for(rx_on, 1, n);
    wait_for(rx_on, 0, n);
    wait_for(sleep_on, 1, n);
    wait_for(rx_on, 1, n);
    wait_for(rx_on, 0, n);
    sync_en <= 1;
    wait_for(rx_on, 1, n);
    repeat (40) @(posedge sys_clk);
    chk(rx_on, 1);
    chk(event_output_line[2], 1);
    chk(event_output_line[4], 1);
    bus(OFS_STATUS, 0, 0, q);
    chk(q[3], 0);
    sync_en <= 0;
    bus(OFS_SEQ_CFG_ONE, 1, cfg1(0), q);
    wait_for(tx_on, 1, n);
    wait_for(tx_on, 0, a);
    wait_for(tx_on, 1, n);
    p1 = a + n;
    wait_for(tx_on, 0, a);
    wait_for(sleep_on, 1, n);
    wait_for(tx_on, 1, p2);
    p2 = p2 + n + a;
    chk(p1, p2);
    wait_for(tx_on, 0, n);
    chk(resends, 3);
    bus(OFS_SEQ_CFG_ONE, 1, 32'h2, q);
    n = 0;
    repeat (4 * (1 + t2) * T + 20) begin
      @(posedge sys_clk);
      if (tx_on !== 1'b0) n++;
    end
    chk(n, 0);
    chk(rc_osc_on, 0);
    summarize;
  end
endmodule
`default_nettype wire

// File: rts_sequencer_chk.sv
`default_nettype none
module rts_sequencer_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic sync_word_match_in,
  input wire logic packet_done_tx_in,
  input wire logic rx_on,
  input wire logic tx_on,
  input wire logic sleep_on,
  input wire logic rc_osc_on,
  input wire logic payload_resend
);
  // ********
  // sequences
  // ********
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_sync_seen;
    $rose(sync_word_match_in) && rx_on ##1 rx_on [*3];
  endsequence
  sequence s_sent;
    $rose(packet_done_tx_in) && tx_on;
  endsequence
  // ********
  // properties
  // ********
  a_ack_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack held longer than one cycle");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
    else $error("ack without request");
  a_mode_excl: assert property (!(rx_on && tx_on))
    else $error("receive and transmit together");
  a_sleep_osc: assert property (sleep_on |-> rc_osc_on)
    else $error("sleep without rc oscillator");
  a_sleep_quiet: assert property (sleep_on |-> !rx_on && !tx_on)
    else $error("radio active in sleep");
  a_resend_once: assert property (payload_resend |=> !payload_resend)
    else $error("resend pulse too long");
  a_resend_tx: assert property (payload_resend |-> ##[0:2] tx_on)
    else $error("resend without transmit");
  a_tx_done: assert property (s_sent |-> ##[1:8] !tx_on)
    else $error("transmit not left after packet sent");
  a_sync_hold: assert property (s_sync_seen |-> ##3 rx_on [*8])
    else $error("receive dropped after sync match");
endmodule
bind rts_sequencer rts_sequencer_chk rts_sequencer_chk_i (.*);
`default_nettype wire
